// file: sim/tap_master.sv
// board-level test controller model driving the test access port
`timescale 1ns/1ps
module tap_master
(
    input wire logic i_clk_sys,
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    // tck stands low until the first frame
    initial
    begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h0;
    end
    // one tck period is 8 clocks; tms and tdi move only while tck is low
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tck <= 1'h0;
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (4) @(posedge i_clk_sys);
        o_tck <= 1'h1;
        repeat (4) @(posedge i_clk_sys);
        // tdo changed at the fall that opened this period, long settled now
        tdo = i_tdo;
    endtask : tick
    // five tms-high periods reach test-logic-reset from anywhere
    task automatic to_idle();
        logic t;
        repeat (5) tick(1'h1, 1'h0, t);
        tick(1'h0, 1'h0, t);
    endtask : to_idle
    // from idle: select, capture, shift n bits lsb first, update, idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic t;
        dout = 32'h0;
        tick(1'h1, 1'h0, t);
        if (ir)
        begin
            tick(1'h1, 1'h0, t);
        end
        tick(1'h0, 1'h0, t);
        tick(1'h0, 1'h0, t);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], dout[i]);
        end
        tick(1'h1, 1'h0, t);
        tick(1'h0, 1'h0, t);
    endtask : scan
endmodule : tap_master

// file: sim/test_boundary_scan_tap.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
module test_boundary_scan_tap;
    import tap_pkg::*;
    logic i_clk_sys;
    logic i_rst;
    logic i_trst_n;
    logic [NUM_IO-1:0] pin_in;
    logic [NUM_IO-1:0] core_out;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic tdo_line;
    logic [NUM_IO-1:0] core_in;
    logic [NUM_IO-1:0] pin_out;
    logic [31:0] got;
    int n_mismatch;
    int n_tests;
    boundary_scan_tap i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .i_trst_n(i_trst_n), .i_pin_in(pin_in), .i_core_out(core_out),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_core_in(core_in), .o_pin_out(pin_out));
    // board pull-up: a released test output reads high, not its last driven value
    assign tdo_line = tdo_oe ? tdo : 1'h1;
    tap_master i_ctl (.i_clk_sys(i_clk_sys), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi));
    // 25 MHz system clock
    initial
    begin
        i_clk_sys = 1'h0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    task automatic check_vec(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_vec
    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // the capture pattern leaves while the new code enters
    task automatic load_ir(input logic [3:0] code);
        i_ctl.scan(1'h1, IR_LEN, {28'h0, code}, got);
        check_vec(got, {28'h0, IR_CAPTURE});
    endtask : load_ir
    // identification code leaves bit 0 first, no instruction load needed
    task automatic t_idcode();
        i_ctl.scan(1'h0, ID_LEN, 32'h0, got);
        check_vec(got, ID_VALUE);
    endtask : t_idcode
    // one-bit path: captured zero, then tdi one period late
    task automatic t_bypass(input logic [3:0] code);
        load_ir(code);
        i_ctl.scan(1'h0, 32, 32'hc3a5_5a3c, got);
        check_vec(got, 32'h874a_b478);
    endtask : t_bypass
    // inputs captured, shifted data held, pins still functional
    task automatic t_sample();
        pin_in <= 4'h9;
        core_out <= 4'h6;
        load_ir(IR_SAMPLE);
        i_ctl.scan(1'h0, 32, 32'h3c12_3456, got);
        check_vec(got, 32'h1234_5669);
        check_vec({28'h0, pin_out}, 32'h6);
        check_vec({28'h0, core_in}, 32'h9);
    endtask : t_sample
    // core output moved first so a functional pin path would show it
    task automatic t_extest();
        core_out <= 4'h1;
        load_ir(IR_EXTEST);
        check_vec({28'h0, pin_out}, 32'h3);
        check_vec({28'h0, core_in}, 32'hc);
        i_ctl.scan(1'h0, 32, 32'ha5f0_0f00, got);
        check_vec({24'h0, got[7:0]}, 32'h19);
        check_vec({got[31:8], 8'h0}, 32'hf00f_0000);
        check_vec({28'h0, pin_out}, 32'ha);
        check_vec({28'h0, core_in}, 32'h5);
    endtask : t_extest
    // bypass path while held cells keep driving the pins
    task automatic t_clamp();
        t_bypass(IR_CLAMP);
        check_vec({28'h0, pin_out}, 32'ha);
    endtask : t_clamp
    // test reset in mid-shift with tck standing still
    task automatic t_trst();
        logic t;
        i_ctl.tick(1'h1, 1'h0, t);
        repeat (3) i_ctl.tick(1'h0, 1'h0, t);
        check_vec({31'h0, tdo_oe}, 32'h1);
        i_trst_n <= 1'h0;
        repeat (2) @(posedge i_clk_sys);
        check_vec({31'h0, tdo_oe}, 32'h0);
        check_vec({28'h0, pin_out}, 32'h1);
        i_trst_n <= 1'h1;
        i_ctl.tick(1'h0, 1'h0, t);
        t_idcode();
    endtask : t_trst
    initial
    begin
        i_rst = 1'h1;
        i_trst_n = 1'h0;
        pin_in = 4'h0;
        core_out = 4'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'h0;
        i_trst_n <= 1'h1;
        repeat (4) @(posedge i_clk_sys);
        i_ctl.to_idle();
        t_idcode();
        t_bypass(IR_BYPASS);
        t_bypass(4'h7);
        t_sample();
        t_extest();
        t_clamp();
        t_trst();
        close_out();
    end
    // the sequence needs about 2,600 clocks; allow nearly four times that
    initial
    begin
        #400000;
        n_mismatch++;
        close_out();
    end
endmodule : test_boundary_scan_tap

// file: verilog/boundary_scan_tap.sv
// boundary-scan tap controller, instruction, bypass and identification registers
//
// Operation
// - Bypass routes test input to test output through one single-bit register.
// - External test lets the boundary cells drive the pins and observe them.
// - Sample captures the pin inputs into the boundary register without disturbing function.
// - Sample also lets data be shifted in and held in the cells' update stages.
// - Clamp selects the bypass register while boundary cells drive the pins as in external test.
// - The identification instruction puts maker, part and version on the scan path.
// - Entering test-logic-reset loads the identification instruction.
// - Test reset low forces test-logic-reset at once, with no test clock edge.
// - The identification register is 32 bits of maker, part and version fields.
// - With identification selected, that register sits between test input and output.
// - Capture-data-register loads the fixed code, which shift states then move out.
// - Bit 31 is nearest the test input and bit 0 nearest the output, leaving first.
`timescale 1ns/1ps
module boundary_scan_tap
    import tap_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    input wire logic [NUM_IO-1:0] i_pin_in,
    input wire logic [NUM_IO-1:0] i_core_out,
    output logic o_tdo,
    output logic o_tdo_oe,
    output logic [NUM_IO-1:0] o_core_in,
    output logic [NUM_IO-1:0] o_pin_out
);
    // test reset acts without any clock, alongside the system reset
    logic tap_arst;
    assign tap_arst = i_rst | ~i_trst_n;

    // pin inputs pass two flops; a third tck flop feeds the edge finder
    logic [1:0] tck_sync_r;
    logic [1:0] tms_sync_r;
    logic [1:0] tdi_sync_r;
    logic tck_last_r;
    // pin inputs for capture also pass two flops; the functional path stays direct
    logic [NUM_IO-1:0] pin_meta_r;
    logic [NUM_IO-1:0] pin_s_r;
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            tck_sync_r <= '0;
            tms_sync_r <= '0;
            tdi_sync_r <= '0;
            tck_last_r <= 1'b0;
            pin_meta_r <= '0;
            pin_s_r <= '0;
        end
        else
        begin
            tck_sync_r <= {tck_sync_r[0], i_tck};
            tms_sync_r <= {tms_sync_r[0], i_tms};
            tdi_sync_r <= {tdi_sync_r[0], i_tdi};
            tck_last_r <= tck_sync_r[1];
            pin_meta_r <= i_pin_in;
            pin_s_r <= pin_meta_r;
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    assign tck_rise = tck_sync_r[1] & ~tck_last_r;
    assign tck_fall = ~tck_sync_r[1] & tck_last_r;
    assign tms_s = tms_sync_r[1];
    assign tdi_s = tdi_sync_r[1];

    // standard sixteen-state walk on mode select
    function automatic tap_state_type tap_next(input tap_state_type s, input logic m);
        tap_state_type n;
        n = s;
        unique case (s)
            TEST_LOGIC_RESET: n = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: n = m ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: n = m ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: n = m ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: n = m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: n = m ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: n = m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: n = m ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: n = m ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: n = m ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: n = m ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: n = m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: n = m ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: n = m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: n = m ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: n = m ? SELECT_DR : RUN_TEST_IDLE;
        endcase
        return n;
    endfunction : tap_next

    tap_state_type state_r;
    always_ff @(posedge i_clk_sys or posedge tap_arst)
    begin
        if (tap_arst)
            state_r <= TEST_LOGIC_RESET;
        else if (tck_rise)
            state_r <= tap_next(state_r, tms_s);
    end

    // instruction shift stage and active instruction
    logic [IR_LEN-1:0] ir_shift_r;
    logic [IR_LEN-1:0] ir_r;
    always_ff @(posedge i_clk_sys or posedge tap_arst)
    begin
        if (tap_arst)
            ir_shift_r <= IR_CAPTURE;
        else if (tck_rise && state_r == CAPTURE_IR)
            ir_shift_r <= IR_CAPTURE;
        else if (tck_rise && state_r == SHIFT_IR)
            ir_shift_r <= {tdi_s, ir_shift_r[IR_LEN-1:1]};
    end

    // update on the falling edge so the new instruction is stable for the next rise
    always_ff @(posedge i_clk_sys or posedge tap_arst)
    begin
        if (tap_arst)
            ir_r <= IR_RESET;
        else if (state_r == TEST_LOGIC_RESET)
            ir_r <= IR_RESET;
        else if (tck_fall && state_r == UPDATE_IR)
            ir_r <= ir_shift_r;
    end

    // data register selection; unknown codes fall back to bypass
    logic sel_bsr;
    logic sel_id;
    logic pins_from_bsr;
    assign sel_bsr = (ir_r == IR_EXTEST) || (ir_r == IR_SAMPLE);
    assign sel_id = (ir_r == IR_IDCODE);
    assign pins_from_bsr = (ir_r == IR_EXTEST) || (ir_r == IR_CLAMP);

    logic cap_dr;
    logic sh_dr;
    assign cap_dr = tck_rise && state_r == CAPTURE_DR;
    assign sh_dr = tck_rise && state_r == SHIFT_DR;

    // single-bit bypass path
    logic bypass_r;
    always_ff @(posedge i_clk_sys or posedge tap_arst)
    begin
        if (tap_arst)
            bypass_r <= BYPASS_CAPTURE;
        else if (cap_dr && !sel_bsr && !sel_id)
            bypass_r <= BYPASS_CAPTURE;
        else if (sh_dr && !sel_bsr && !sel_id)
            bypass_r <= tdi_s;
    end

    // identification register, bit 0 leaves first
    logic [ID_LEN-1:0] id_r;
    always_ff @(posedge i_clk_sys or posedge tap_arst)
    begin
        if (tap_arst)
            id_r <= ID_VALUE;
        else if (cap_dr && sel_id)
            id_r <= ID_VALUE;
        else if (sh_dr && sel_id)
            id_r <= {tdi_s, id_r[ID_LEN-1:1]};
    end

    // boundary cells: low half sees pin inputs, high half sees core outputs
    logic bsr_so;
    logic [BSR_LEN-1:0] bsr_upd;
    scan_cells u_cells (
        .i_clk_sys(i_clk_sys),
        .i_rst(tap_arst),
        .i_capture(cap_dr && sel_bsr),
        .i_shift(sh_dr && sel_bsr),
        .i_update(tck_fall && state_r == UPDATE_DR && sel_bsr),
        .i_si(tdi_s),
        .i_par({i_core_out, pin_s_r}),
        .o_so(bsr_so),
        .o_upd(bsr_upd)
    );

    // pins follow the held stage only in extest and clamp, so sample never disturbs
    assign o_pin_out = pins_from_bsr ? bsr_upd[BSR_LEN-1:NUM_IO] : i_core_out;
    assign o_core_in = (ir_r == IR_EXTEST) ? bsr_upd[NUM_IO-1:0] : i_pin_in;

    logic dr_so;
    assign dr_so = sel_bsr ? bsr_so : (sel_id ? id_r[0] : bypass_r);

    // test output changes on the falling edge, driven only while shifting
    always_ff @(posedge i_clk_sys or posedge tap_arst)
    begin
        if (tap_arst)
        begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            o_tdo <= (state_r == SHIFT_IR) ? ir_shift_r[0] : dr_so;
            o_tdo_oe <= (state_r == SHIFT_IR) || (state_r == SHIFT_DR);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (tap_arst);

    property trst_force_p;
        @(posedge i_clk_sys) disable iff (i_rst) !i_trst_n |-> state_r == TEST_LOGIC_RESET;
    endproperty
    trst_force_a: assert property (trst_force_p) else $error("test reset did not force reset state");

    reset_ir_a: assert property (tck_rise && state_r == TEST_LOGIC_RESET |=> ir_r == IR_IDCODE)
        else $error("reset state did not load identification instruction");

    bypass_cap_a: assert property (cap_dr && ir_r == IR_BYPASS |=> bypass_r == 1'b0)
        else $error("bypass did not capture zero");

    bypass_path_a: assert property (tck_fall && state_r == SHIFT_DR
        && !sel_bsr && !sel_id |=> o_tdo == $past(bypass_r))
        else $error("bypass bit not on test output");

    id_cap_a: assert property (cap_dr && sel_id |=> id_r == ID_VALUE && id_r[0])
        else $error("identification code not captured");

    id_shift_a: assert property (sh_dr && sel_id
        |=> id_r == {$past(tdi_s), $past(id_r[ID_LEN-1:1])})
        else $error("identification shift order wrong");

    clamp_pins_a: assert property (ir_r == IR_CLAMP |-> o_pin_out == bsr_upd[BSR_LEN-1:NUM_IO]
        && !sel_bsr)
        else $error("clamp does not hold pins from boundary cells");

    sample_quiet_a: assert property (ir_r == IR_SAMPLE |-> o_pin_out == i_core_out
        && o_core_in == i_pin_in)
        else $error("sample disturbs functional pins");

    tdo_drive_a: assert property (tck_fall && state_r == SHIFT_DR |=> o_tdo_oe)
        else $error("test output not driven while shifting");

    id_walk_c: cover property (cap_dr && sel_id ##[1:200] sh_dr && sel_id);
    ir_load_c: cover property (tck_fall && state_r == UPDATE_IR ##1 ir_r == IR_EXTEST);
    clamp_c: cover property (ir_r == IR_CLAMP && sh_dr);
endmodule : boundary_scan_tap

// file: verilog/scan_cells.sv
// boundary-scan register: capture/shift stage plus held update stage
`timescale 1ns/1ps
module scan_cells
    import tap_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_capture,
    input wire logic i_shift,
    input wire logic i_update,
    input wire logic i_si,
    input wire logic [BSR_LEN-1:0] i_par,
    output logic o_so,
    output logic [BSR_LEN-1:0] o_upd
);
    logic [BSR_LEN-1:0] shift_r;
    logic [BSR_LEN-1:0] upd_r;

    // capture parallel values or shift toward the low end
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            shift_r <= '0;
        else if (i_capture)
            shift_r <= i_par;
        else if (i_shift)
            shift_r <= {i_si, shift_r[BSR_LEN-1:1]};
    end

    // held output stage keeps preloaded data until the next update
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            upd_r <= '0;
        else if (i_update)
            upd_r <= shift_r;
    end

    assign o_so = shift_r[0];
    assign o_upd = upd_r;
endmodule : scan_cells

// file: verilog/tap_pkg.sv
// constants and types for the boundary-scan test access port
package tap_pkg;
    // instruction register
    localparam int IR_LEN = 4;
    localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h2;
    localparam logic [IR_LEN-1:0] IR_CLAMP = 4'h3;
    localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hf;
    // fixed capture pattern of the instruction register, low bits 01
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
    // instruction loaded on entry to test-logic-reset
    localparam logic [IR_LEN-1:0] IR_RESET = IR_IDCODE;

    // identification register layout, values arbitrary
    localparam int ID_LEN = 32;
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h0a5c;
    localparam logic [10:0] ID_MAKER = 11'h02a;
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // bypass register captures zero
    localparam logic BYPASS_CAPTURE = 1'b0;

    // boundary-scan cells per direction
    localparam int NUM_IO = 4;
    localparam int BSR_LEN = 2 * NUM_IO;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_type;
endpackage : tap_pkg
